// ### mpeb_pkg.sv
// Purpose: Shared constants for the port and external bus block
// Assumes: One 10 MHz oscillator clock, 12 clocks per machine cycle
// Notes: States phase the machine cycle in six steps of two clocks
package mpeb_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int OSC_PER_STATE = 2;
  localparam int STATES_PER_MC = 6;
  localparam logic [3:0] MC_LAST = 4'hb;
  // Strobe phase positions inside the machine cycle
  localparam logic [3:0] ALE_PH0 = 4'h0;
  localparam logic [3:0] ALE_PH1 = 4'h6;
  localparam logic [3:0] PROGRAM_STORE_STROBE_PH0_START = 4'h2;
  localparam logic [3:0] PROGRAM_STORE_STROBE_PH0_END = 4'h5;
  localparam logic [3:0] PROGRAM_STORE_STROBE_PH1_START = 4'h8;
  localparam logic [3:0] PROGRAM_STORE_STROBE_PH1_END = 4'hb;
  localparam logic [3:0] DATA_PH = 4'h3;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [15:0] INTERNAL_CODE_TOP = 16'h1fff;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    MPEB_IDLE = 2'b00,
    MPEB_FETCH = 2'b01,
    MPEB_DATA = 2'b10
  } mpeb_cyc_e;
endpackage

// ### mpeb_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk_sys
// Notes: Stage one feeds only stage two
`timescale 1ns/100ps
module mpeb_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins and clean level
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] cleanOut
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, clean_reg, clean_next;
  always_comb begin
    clean_next = clean_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        clean_next[i] = s3_reg[i];
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      clean_reg <= '1;
    end else begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      clean_reg <= clean_next;
    end
  end
  assign cleanOut = clean_reg;
endmodule

// ### mpeb_ports.sv
// Purpose: Port pins, multiplexed external bus and strobes of a microcontroller
// Assumes: Core supplies latches, bus requests and alternate outputs on clk_sys
// Notes: Pullups are modelled as drive enables; weak pullup reads as pin released
`timescale 1ns/100ps
// Notes on behaviour
// - Low-bus port pin with latch one floats, serving as open-drain input.
// - External accesses multiplex low address then data, driving ones actively.
// - Other ports with latch one are weakly pulled high, readable as input.
// - Port one bit 0 is third timer clock, bit 1 its trigger.
// - High-bus port drives upper address for fetches and pointer data accesses.
// - Register-indirect data accesses keep the high-bus port latch on pins.
// - Port three alternates: rx, tx, two interrupts, two counts, write, read.
// - Reset forces ports one, two, three high asynchronously.
// - Address-latch strobe pulses at one sixth of oscillator rate outside external data accesses.
// - One address-latch pulse is omitted during each external data access.
// - Verification mode outputs code bytes on low-bus port; outside pulls up.
// - Program strobe pulses twice per fetch cycle, skips two for data access.
// - Access select high fetches internally below top; low fetches externally.
module mpeb_ports (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Core port latches and requests
  input wire logic [7:0] port0Latch,
  input wire logic [7:0] port1Latch,
  input wire logic [7:0] port2OutputLatch,
  input wire logic [7:0] port3Latch,
  input wire logic [15:0] programCounter,
  input wire logic dataReq,
  input wire logic dataWrite,
  input wire logic dataUsePointer,
  input wire logic [15:0] dataAddr,
  input wire logic [7:0] dataWrByte,
  input wire logic verifyMode,
  input wire logic [7:0] verifyCodeByte,
  input wire logic serialTxOut,
  // Pins
  input wire logic externalAccessSelect,
  input wire logic [7:0] port0In,
  output logic [7:0] port0Out,
  output logic [7:0] port0Oe,
  input wire logic [7:0] port1In,
  output logic [7:0] port1Out,
  output logic [7:0] port1Oe,
  input wire logic [7:0] port2In,
  output logic [7:0] port2Out,
  output logic [7:0] port2Oe,
  input wire logic [7:0] port3In,
  output logic [7:0] port3Out,
  output logic [7:0] port3Oe,
  output logic addrLatchStrobe,
  output logic programStoreStrobe_n,
  // Synchronised pin levels and alternate inputs to the core
  output logic [7:0] port0Sync,
  output logic [7:0] port1Sync,
  output logic [7:0] port2Sync,
  output logic [7:0] port3Sync,
  output logic timer2ExtClock,
  output logic timer2TriggerInput,
  output logic serialRxIn,
  output logic extInterruptZero,
  output logic extInterruptOne,
  output logic timer0CountInput,
  output logic timer1CountInput,
  output logic [7:0] dataRdByte,
  output logic dataDone,
  output logic fetchExternal
);
  logic [3:0] phase_reg, phase_next;
  mpeb_pkg::mpeb_cyc_e cyc_reg, cyc_next;
  logic [15:0] addr_reg, addr_next;
  logic wr_reg, wr_next, ptr_reg, ptr_next;
  logic [7:0] wdat_reg, wdat_next, rdat_reg, rdat_next;
  logic done_reg, done_next;
  logic [7:0] p0o_next, p0e_next, p1o_next, p1e_next, p2o_next, p2e_next, p3o_next, p3e_next;
  logic ale_next, program_store_strobe_next;
  logic [7:0] p0o_reg, p0e_reg, p1o_reg, p1e_reg, p2o_reg, p2e_reg, p3o_reg, p3e_reg;
  logic ale_reg, program_store_strobe_reg, fext_reg;
  logic [7:0] s0, s1, s2, s3;
  logic fextNext;
  logic eaSync;

  mpeb_sync #(.WIDTH(32)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn({port3In, port2In, port1In, port0In}),
    .cleanOut({s3, s2, s1, s0})
  );

  // Access select is a pin too; a raw level could split one fetch decision
  mpeb_sync #(.WIDTH(1)) u_sync_sel (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn(externalAccessSelect),
    .cleanOut(eaSync)
  );

  // Quasi-bidirectional pin: drive low for zero, weak pullup (released) for one
  function automatic logic [7:0] quasiOe(input logic [7:0] latch);
    return ~latch;
  endfunction

  always_comb begin
    // external fetch when select low or counter beyond internal top
    fextNext = !eaSync || (programCounter > mpeb_pkg::INTERNAL_CODE_TOP);
    phase_next = (phase_reg == mpeb_pkg::MC_LAST) ? 4'h0 : phase_reg + 4'h1;
    cyc_next = cyc_reg;
    addr_next = addr_reg;
    wr_next = wr_reg;
    ptr_next = ptr_reg;
    wdat_next = wdat_reg;
    rdat_next = rdat_reg;
    done_next = 1'b0;
    if (phase_reg == mpeb_pkg::MC_LAST) begin
      if (cyc_reg == mpeb_pkg::MPEB_DATA) begin
        done_next = 1'b1;
      end
      if (dataReq && !verifyMode) begin
        cyc_next = mpeb_pkg::MPEB_DATA;
        addr_next = dataAddr;
        wr_next = dataWrite;
        ptr_next = dataUsePointer;
        wdat_next = dataWrByte;
      end else if (fextNext) begin
        cyc_next = mpeb_pkg::MPEB_FETCH;
        addr_next = programCounter;
      end else begin
        cyc_next = mpeb_pkg::MPEB_IDLE;
      end
    end
    if (cyc_reg == mpeb_pkg::MPEB_DATA && !wr_reg && phase_reg == mpeb_pkg::PROGRAM_STORE_STROBE_PH1_END) begin
      rdat_next = s0;
    end
    // two pulses per machine cycle, i.e. one sixth of the clock
    ale_next = (phase_next == mpeb_pkg::ALE_PH0) || (phase_next == mpeb_pkg::ALE_PH1);
    if (cyc_reg == mpeb_pkg::MPEB_DATA && phase_next == mpeb_pkg::ALE_PH1) begin
      ale_next = 1'b0;
    end
    program_store_strobe_next = 1'b1;
    if (cyc_next == mpeb_pkg::MPEB_FETCH || (phase_next != 4'h0 && cyc_reg == mpeb_pkg::MPEB_FETCH)) begin
      // two strobes in a fetch cycle; none in data or internal cycles
      if ((phase_next >= mpeb_pkg::PROGRAM_STORE_STROBE_PH0_START && phase_next <= mpeb_pkg::PROGRAM_STORE_STROBE_PH0_END) ||
          (phase_next >= mpeb_pkg::PROGRAM_STORE_STROBE_PH1_START && phase_next <= mpeb_pkg::PROGRAM_STORE_STROBE_PH1_END)) begin
        program_store_strobe_next = 1'b0;
      end
    end
    // Normal port behaviour
    p0o_next = 8'h00;
    p0e_next = quasiOe(port0Latch);
    p1o_next = 8'h00;
    p1e_next = quasiOe(port1Latch);
    p2o_next = 8'h00;
    p2e_next = quasiOe(port2OutputLatch);
    p3o_next = {7'h00, 1'b0};
    p3e_next = quasiOe(port3Latch & {6'h3f, serialTxOut, 1'b1});
    if (verifyMode) begin
      // code bytes driven only as pull-downs; outside pulls up
      p0e_next = ~verifyCodeByte;
      p1e_next = 8'h00;
      p2e_next = 8'h00;
    end else if (cyc_next != mpeb_pkg::MPEB_IDLE) begin
      // address phase then data phase, ones driven actively
      p0e_next = 8'hff;
      p0o_next = addr_next[7:0];
      if (cyc_next == mpeb_pkg::MPEB_DATA && phase_next >= mpeb_pkg::DATA_PH) begin
        p0o_next = wdat_next;
        p0e_next = wr_next ? 8'hff : 8'h00;
      end else if (cyc_next == mpeb_pkg::MPEB_FETCH && phase_next >= mpeb_pkg::DATA_PH) begin
        p0e_next = 8'h00;
      end
      if (cyc_next == mpeb_pkg::MPEB_FETCH || ptr_next) begin
        p2o_next = addr_next[15:8];
        p2e_next = 8'hff;
      end
      // strobes low only inside the data cycle
      if (cyc_next == mpeb_pkg::MPEB_DATA && phase_next >= mpeb_pkg::DATA_PH) begin
        p3e_next[6] = p3e_next[6] | wr_next;
        p3e_next[7] = p3e_next[7] | !wr_next;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg <= 4'h0;
      cyc_reg <= mpeb_pkg::MPEB_IDLE;
      addr_reg <= 16'h0000;
      wr_reg <= 1'b0;
      ptr_reg <= 1'b0;
      wdat_reg <= 8'h00;
      rdat_reg <= 8'h00;
      done_reg <= 1'b0;
      fext_reg <= 1'b0;
      ale_reg <= 1'b0;
      program_store_strobe_reg <= 1'b1;
      // forced high without waiting for a clock edge
      p0o_reg <= 8'h00;
      p0e_reg <= 8'h00;
      p1o_reg <= 8'h00;
      p1e_reg <= 8'h00;
      p2o_reg <= 8'h00;
      p2e_reg <= 8'h00;
      p3o_reg <= 8'h00;
      p3e_reg <= 8'h00;
    end else begin
      phase_reg <= phase_next;
      cyc_reg <= cyc_next;
      addr_reg <= addr_next;
      wr_reg <= wr_next;
      ptr_reg <= ptr_next;
      wdat_reg <= wdat_next;
      rdat_reg <= rdat_next;
      done_reg <= done_next;
      fext_reg <= fextNext;
      ale_reg <= ale_next;
      program_store_strobe_reg <= program_store_strobe_next;
      p0o_reg <= p0o_next;
      p0e_reg <= p0e_next;
      p1o_reg <= p1o_next;
      p1e_reg <= p1e_next;
      p2o_reg <= p2o_next;
      p2e_reg <= p2e_next;
      p3o_reg <= p3o_next;
      p3e_reg <= p3e_next;
    end
  end

  // Pin outputs and synchronised alternate inputs
  assign port0Out = p0o_reg;
  assign port0Oe = p0e_reg;
  assign port1Out = p1o_reg;
  assign port1Oe = p1e_reg;
  assign port2Out = p2o_reg;
  assign port2Oe = p2e_reg;
  assign port3Out = p3o_reg;
  assign port3Oe = p3e_reg;
  assign addrLatchStrobe = ale_reg;
  assign programStoreStrobe_n = program_store_strobe_reg;
  assign port0Sync = s0;
  assign port1Sync = s1;
  assign port2Sync = s2;
  assign port3Sync = s3;
  assign timer2ExtClock = s1[0];
  assign timer2TriggerInput = s1[1];
  assign serialRxIn = s3[0];
  assign extInterruptZero = s3[2];
  assign extInterruptOne = s3[3];
  assign timer0CountInput = s3[4];
  assign timer1CountInput = s3[5];
  assign dataRdByte = rdat_reg;
  assign dataDone = done_reg;
  assign fetchExternal = fext_reg;

  a_ale_cadence: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == mpeb_pkg::MC_LAST || (phase_reg == 4'h5 && cyc_reg != mpeb_pkg::MPEB_DATA)) |=> addrLatchStrobe)
    else $error("address strobe missing at cycle start");
  a_ale_skip: assert property (@(posedge clk_sys) disable iff (rst)
    (phase_reg == 4'h5 && cyc_reg == mpeb_pkg::MPEB_DATA) |-> ##1 !addrLatchStrobe)
    else $error("address strobe not skipped in data cycle");
  a_program_store_strobe_data: assert property (@(posedge clk_sys) disable iff (rst)
    (cyc_reg == mpeb_pkg::MPEB_DATA && phase_reg != 4'h0) |-> programStoreStrobe_n)
    else $error("program strobe active in data cycle");
  a_strobe_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (cyc_reg != mpeb_pkg::MPEB_DATA) |-> !port3Oe[6] || !$past(port3Latch[6]))
    else $error("write strobe outside data cycle");
  a_p1_quasi: assert property (@(posedge clk_sys) disable iff (rst)
    !verifyMode |=> port1Oe == ~$past(port1Latch))
    else $error("port one drive wrong");
  a_p2_addr: assert property (@(posedge clk_sys) disable iff (rst)
    (cyc_reg == mpeb_pkg::MPEB_FETCH && !verifyMode && phase_reg == 4'h1) |-> port2Oe == 8'hff && port2Out == addr_reg[15:8])
    else $error("high address missing on fetch");
  a_p0_verify: assert property (@(posedge clk_sys) disable iff (rst)
    verifyMode |=> port0Oe == ~$past(verifyCodeByte))
    else $error("code byte not shown in verification");
  a_p0_float: assert property (@(posedge clk_sys) disable iff (rst)
    (!verifyMode && cyc_next == mpeb_pkg::MPEB_IDLE) |=> port0Oe == ~$past(port0Latch))
    else $error("low bus not released");
endmodule

// ### mpeb_ext_mem.sv
// Purpose: Far-side model: address latch, code store and data memory
// Assumes: Strobes and pins seen as resolved wire levels
// Notes: Behavioural; bus released outside strobes so pull-ups win
`timescale 1ns/100ps
module mpeb_ext_mem (
  // Strobes
  input wire logic addrLatchStrobe,
  input wire logic programStoreStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic readStrobe_n,
  // Bus pins
  input wire logic [7:0] busIn,
  input wire logic [7:0] highIn,
  output logic [7:0] busOut,
  output logic busOe,
  output logic [7:0] lowAddr
);
  logic [7:0] dataMem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      dataMem[i] = 8'(i) ^ 8'h3c;
    end
  end
  // Low byte held for the rest of the access
  always @(negedge addrLatchStrobe) lowAddr <= busIn;
  // Take data mid-strobe, well inside the data phases
  always @(negedge writeStrobe_n) begin
    #200 dataMem[lowAddr] = busIn;
  end
  // Code byte is a simple function of the address
  assign busOe = !programStoreStrobe_n || !readStrobe_n;
  assign busOut = !programStoreStrobe_n ? (lowAddr ^ highIn) : dataMem[lowAddr];
endmodule

// ### mpeb_ports_tb_top.sv
// Purpose: Self-checking bench for the port and external bus block
// Assumes: Weak pullups modelled as released pins with pull-up to one
// Notes: Inputs change on the falling edge, except rst and the latches in testReset, set 20 and 25 ns after one
`timescale 1ns/100ps
module mpeb_ports_tb_top;
  logic clk_sys, rst, dataReq, dataWrite, dataUsePointer, verifyMode, serialTxOut, externalAccessSelect;
  logic dataDone, fetchExternal, addrLatchStrobe, programStoreStrobe_n, timer2ExtClock, timer2TriggerInput;
  logic serialRxIn, extInterruptZero, extInterruptOne, timer0CountInput, timer1CountInput, memOe;
  logic [7:0] port0Latch, port1Latch, port2OutputLatch, port3Latch, dataWrByte, verifyCodeByte;
  logic [7:0] port0In, port1In, port2In, port3In, port0Out, port1Out, port2Out, port3Out;
  logic [7:0] port0Oe, port1Oe, port2Oe, port3Oe, port0Sync, port1Sync, port2Sync, port3Sync;
  logic [7:0] dataRdByte, p1Ext, p2Ext, p3Ext, memOut, lowAddr;
  logic [15:0] programCounter, dataAddr;
  int badCount, checked;
  // Pin levels; external pull-ups on the low bus
  assign port0In = (port0Oe & port0Out) | (~port0Oe & (memOe ? memOut : 8'hff));
  // Driven bits follow the port output; released bits read the outside level
  assign port1In = (port1Oe & port1Out) | (~port1Oe & p1Ext);
  assign port2In = (port2Oe & port2Out) | (~port2Oe & p2Ext);
  assign port3In = (port3Oe & port3Out) | (~port3Oe & p3Ext);
  mpeb_ports uut (.clk_sys, .rst, .port0Latch, .port1Latch, .port2OutputLatch, .port3Latch,
    .programCounter, .dataReq, .dataWrite, .dataUsePointer, .dataAddr, .dataWrByte, .verifyMode,
    .verifyCodeByte, .serialTxOut, .externalAccessSelect, .port0In, .port0Out, .port0Oe, .port1In,
    .port1Out, .port1Oe, .port2In, .port2Out, .port2Oe, .port3In, .port3Out, .port3Oe,
    .addrLatchStrobe, .programStoreStrobe_n, .port0Sync, .port1Sync, .port2Sync, .port3Sync,
    .timer2ExtClock, .timer2TriggerInput, .serialRxIn, .extInterruptZero, .extInterruptOne,
    .timer0CountInput, .timer1CountInput, .dataRdByte, .dataDone, .fetchExternal);
  mpeb_ext_mem mem (.addrLatchStrobe, .programStoreStrobe_n, .writeStrobe_n(port3In[6]),
    .readStrobe_n(port3In[7]), .busIn(port0In), .highIn(port2In), .busOut(memOut), .busOe(memOe), .lowAddr);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Latch pulses are one clock wide, so one sample per clock counts each
  task automatic count(input int n, output int a, output int p);
    logic prev;
    a = 0;
    p = 0;
    prev = programStoreStrobe_n;
    repeat (n) begin
      @(negedge clk_sys);
      a += int'(addrLatchStrobe === 1'b1);
      p += int'(prev === 1'b1 && programStoreStrobe_n === 1'b0);
      prev = programStoreStrobe_n;
    end
  endtask
  task automatic testReset;
    port1Latch = 8'h00; port2OutputLatch = 8'h00; port3Latch = 8'h00;
    tick(8);
    cmp8("port1 drive", 8'hff, port1Oe);
    #20 rst = 1'b1;
    #5 cmp8("port1 oe", 8'h00, port1Oe);
    cmp8("port2 oe", 8'h00, port2Oe);
    cmp8("port3 oe", 8'h00, port3Oe);
    port1Latch = 8'hff; port2OutputLatch = 8'hff; port3Latch = 8'hff;
    tick(24);
    rst = 1'b0;
    $display("reset test done");
  endtask
  task automatic testCadence;
    int a, p;
    port0Latch = 8'h0f;
    tick(24);
    count(60, a, p);
    cmp8("ale pulses", 8'd10, 8'(a));
    cmp8("program_store_strobe internal", 8'd0, 8'(p));
    cmp8("port0 oe", 8'hf0, port0Oe);
    cmp8("port0 read", 8'h0f, port0Sync);
    port0Latch = 8'hff;
    $display("cadence test done");
  endtask
  task automatic testFetch(input logic ea, input logic [15:0] pc);
    int a, p, i;
    externalAccessSelect = ea; programCounter = pc;
    tick(24);
    count(24, a, p);
    cmp8("program_store_strobe pulses", 8'd4, 8'(p));
    cmp8("ale fetch", 8'd4, 8'(a));
    cmp8("fetch ext", 8'h01, {7'h0, fetchExternal});
    for (i = 0; i < 24 && programStoreStrobe_n !== 1'b0; i++) tick(1);
    if (programStoreStrobe_n !== 1'b0) begin
      badCount++;
      stop_test();
    end else begin
      cmp8("high addr", pc[15:8], port2In);
      cmp8("low addr", pc[7:0], lowAddr);
    end
    externalAccessSelect = 1'b1; programCounter = 16'h0100;
    tick(24);
    $display("fetch test done");
  endtask
  task automatic access(input logic w, ptr, input logic [15:0] a, input logic [7:0] wb,
    input logic [7:0] expHi, input logic [1:0] expStb);
    logic [39:0] hist;
    logic [7:0] hi;
    logic [1:0] stb;
    int i;
    hist = '0; hi = 8'h00; stb = 2'b00;
    dataReq = 1'b1; dataWrite = w; dataUsePointer = ptr; dataAddr = a; dataWrByte = wb;
    // First pass always runs: the done pulse of the previous access may still stand
    for (i = 0; i < 40 && (i == 0 || dataDone !== 1'b1); i++) begin
      @(negedge clk_sys);
      hist = {hist[38:0], addrLatchStrobe === 1'b1};
      if (port3In[6] === 1'b0) begin stb[1] = 1'b1; hi = port2In; end
      if (port3In[7] === 1'b0) begin stb[0] = 1'b1; hi = port2In; end
      // Cycle is running: withdraw the level so it is not taken a second time
      if (stb != 2'b00) dataReq = 1'b0;
    end
    if (dataDone !== 1'b1) begin
      badCount++;
      stop_test();
    end else begin
      cmp8("ale in data", 8'd1, 8'($countones(hist[11:0])));
      cmp8("high byte", expHi, hi);
      cmp8("strobes", {6'h0, expStb}, {6'h0, stb});
    end
  endtask
  task automatic testData;
    port2OutputLatch = 8'h5a;
    access(1'b1, 1'b1, 16'h4c21, 8'h96, 8'h4c, 2'b10);
    access(1'b0, 1'b0, 16'h9921, 8'h00, 8'h5a, 2'b01);
    cmp8("read back", 8'h96, dataRdByte);
    access(1'b0, 1'b1, 16'h8033, 8'h00, 8'h80, 2'b01);
    cmp8("read ptr", 8'h0f, dataRdByte);
    dataReq = 1'b0;
    cmp8("mem write", 8'h96, mem.dataMem[8'h21]);
    port2OutputLatch = 8'hff;
    $display("data test done");
  endtask
  task automatic altCase(input logic [7:0] e1, e3, input logic tx, input logic [6:0] exp);
    p1Ext = e1; p3Ext = e3; serialTxOut = tx;
    tick(6);
    cmp8("port1 read", e1, port1Sync);
    cmp8("timer2 pins", {6'h0, exp[6:5]}, {6'h0, timer2TriggerInput, timer2ExtClock});
    cmp8("port3 alt", {3'h0, exp[4:0]}, {3'h0, timer1CountInput, timer0CountInput,
      extInterruptOne, extInterruptZero, serialRxIn});
    cmp8("tx pin", {7'h0, tx}, {7'h0, port3In[1]});
    cmp8("port3 read", {e3[7:2], e3[1] & tx, e3[0]}, port3Sync);
  endtask
  task automatic testVerify;
    verifyMode = 1'b1; verifyCodeByte = 8'ha5; p1Ext = 8'h34; p2Ext = 8'h12;
    tick(14);
    cmp8("code byte", 8'ha5, port0In);
    cmp8("port1 free", 8'h00, port1Oe);
    cmp8("port2 free", 8'h00, port2Oe);
    cmp8("addr in", 8'h34, port1Sync);
    cmp8("high in", 8'h12, port2Sync);
    verifyMode = 1'b0; p1Ext = 8'hff; p2Ext = 8'hff;
    tick(14);
    $display("verify test done");
  endtask
  initial begin
    rst = 1'b1; dataReq = 1'b0; dataWrite = 1'b0; dataUsePointer = 1'b0; verifyMode = 1'b0;
    serialTxOut = 1'b1; externalAccessSelect = 1'b1; programCounter = 16'h0100; dataAddr = 16'h0000;
    port0Latch = 8'hff; port1Latch = 8'hff; port2OutputLatch = 8'hff; port3Latch = 8'hff;
    dataWrByte = 8'h00; verifyCodeByte = 8'h00; p1Ext = 8'hff; p2Ext = 8'hff; p3Ext = 8'hff;
    badCount = 0; checked = 0;
    tick(8);
    rst = 1'b0;
    testReset();
    testCadence();
    testFetch(1'b0, 16'h2a5c);
    testFetch(1'b1, 16'h3000);
    testData();
    altCase(8'hfe, 8'hea, 1'b0, 7'b1010100);
    altCase(8'hfd, 8'hd7, 1'b1, 7'b0101011);
    p1Ext = 8'hff; p3Ext = 8'hff;
    $display("alternate test done");
    testVerify();
    stop_test();
  end
endmodule
